/* File: verilog/ssbcr_regs.v */
`timescale 1ns/1ps
`include "ssbcr_defs.vh"
module ssbcr_regs #(
   parameter [15:0] CUSTOMER_ID = `SSBCR_CID_DEFAULT
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_cs,
   input wire [3:0] i_addr,
   input wire i_rd,
   input wire i_wr,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   output reg o_rdata_valid,
   input wire i_controller_irq_n,
   input wire i_dataset_ready_n,
   input wire i_rts_line,
   input wire i_cts_line,
   input wire i_rx_clk_line,
   input wire i_tx_clk_line,
   input wire i_controller_trx_clock_pin,
   input wire i_peripheral_clk,
   input wire i_ref_osc_clk,
   input wire i_tx_driver_en,
   output reg o_controller_sync_pin,
   output reg o_controller_rtx_clock_pin,
   output reg o_tx_element_timing_out,
   output reg o_tx_timing_en,
   output reg o_baud_ref_clk,
   output reg o_echo_disable,
   output reg [3:0] o_line_mode_code,
   output reg o_mode_supported,
   output reg o_drivers_en,
   output reg o_differential,
   output reg o_loopback_mode,
   output reg o_two_wire,
   output reg o_term_en,
   output reg o_remote_loop_ctrl,
   output reg o_local_loop_ctrl
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   wire irq_n_s;
   wire dsr_n_s;
   wire rts_s;
   wire cts_s;
   wire rxc_s;
   wire txc_s;
   wire trxc_s;
   wire pclk_s;
   wire osc_s;
   wire txen_s;
   wire [9:0] pin_raw = {i_tx_driver_en, i_ref_osc_clk, i_peripheral_clk, i_controller_trx_clock_pin,
                         i_tx_clk_line, i_rx_clk_line, i_cts_line, i_rts_line, i_dataset_ready_n,
                         i_controller_irq_n};
   wire [9:0] pin_s;
   genvar g;
   generate
      for (g = 0; g < 10; g = g + 1) begin : g_sync
         ssbcr_sync2 u_sync (
            .i_ref_clk(i_ref_clk),
            .i_rst(i_rst),
            .i_rst_val(1'b1),
            .i_async(pin_raw[g]),
            .o_sync(pin_s[g])
         );
      end
   endgenerate
   assign {txen_s, osc_s, pclk_s, trxc_s, txc_s, rxc_s, cts_s, rts_s, dsr_n_s, irq_n_s} = pin_s;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   reg [7:0] line_interface_control_r;
   reg [3:0] loop_and_clock_select_r;
   wire in_window = i_cs && ({28'h0, i_addr} < `SSBCR_WIN_SIZE);
   wire wr_line = in_window && i_wr && (i_addr == `SSBCR_OFF_LINE_CTRL);
   wire wr_loop = in_window && i_wr && (i_addr == `SSBCR_OFF_LOOP_CLK);

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         line_interface_control_r <= `SSBCR_RST_LINE_CTRL;
         loop_and_clock_select_r <= `SSBCR_RST_LOOP_CLK;
      end else begin
         if (wr_line) begin
            line_interface_control_r <= i_wdata;
         end
         if (wr_loop) begin
            loop_and_clock_select_r <= i_wdata[3:0];
         end
         // writes to the status offset carry no storage and are dropped
      end
   end

   // ----------------------------------------
   // read path, answered one cycle after the strobe
   // ----------------------------------------
   reg [7:0] rdata_nxt;
   always @* begin
      rdata_nxt = 8'h00;
      case (i_addr)
         `SSBCR_OFF_STATUS: begin
            rdata_nxt[`SSBCR_ST_IRQ_BIT] = irq_n_s;
            rdata_nxt[`SSBCR_ST_DSR_BIT] = dsr_n_s;
         end
         `SSBCR_OFF_LINE_CTRL: begin
            rdata_nxt = line_interface_control_r;
         end
         `SSBCR_OFF_LOOP_CLK: begin
            rdata_nxt = {4'h0, loop_and_clock_select_r};
         end
         `SSBCR_OFF_CID_LO: begin
            rdata_nxt = CUSTOMER_ID[7:0];
         end
         `SSBCR_OFF_CID_HI: begin
            rdata_nxt = CUSTOMER_ID[15:8];
         end
         default: begin
            rdata_nxt = 8'h00;
         end
      endcase
   end

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_rdata_valid <= 1'b0;
      end else begin
         o_rdata_valid <= in_window && i_rd;
         if (in_window && i_rd) begin
            o_rdata <= rdata_nxt;
         end
      end
   end

   // ----------------------------------------
   // line mode decode
   // ----------------------------------------
   wire dec_supported;
   wire dec_term;
   wire dec_drv;
   wire dec_diff;
   wire dec_loop;
   wire dec_two;
   ssbcr_mode_dec u_dec (
      .i_line_mode_code(line_interface_control_r[`SSBCR_LC_MODE_MSB:`SSBCR_LC_MODE_LSB]),
      .o_supported(dec_supported),
      .o_term_en(dec_term),
      .o_drivers_en(dec_drv),
      .o_differential(dec_diff),
      .o_loopback(dec_loop),
      .o_two_wire(dec_two)
   );

   // ----------------------------------------
   // routing outputs, all registered
   // ----------------------------------------
   wire sync_rts_sel = line_interface_control_r[`SSBCR_LC_SYNC_RTS_BIT];
   wire sync_cts_sel = line_interface_control_r[`SSBCR_LC_SYNC_CTS_BIT];
   wire timing_follows_tx_driver = line_interface_control_r[`SSBCR_LC_TIMING_SW_BIT];
   reg sync_nxt;
   reg tx_element_timing_out_nxt;
   always @* begin
      // an unselected source holds high so both selects combine by and
      sync_nxt = 1'b1;
      if (sync_rts_sel) begin
         sync_nxt = sync_nxt & rts_s;
      end
      if (sync_cts_sel) begin
         sync_nxt = sync_nxt & cts_s;
      end
      tx_element_timing_out_nxt = loop_and_clock_select_r[`SSBCR_LK_TSRC_BIT] ? txc_s : trxc_s;
   end

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_controller_sync_pin <= 1'b1;
         o_controller_rtx_clock_pin <= 1'b0;
         o_tx_element_timing_out <= 1'b0;
         o_tx_timing_en <= 1'b0;
         o_baud_ref_clk <= 1'b0;
         o_echo_disable <= 1'b0;
         o_line_mode_code <= 4'h0;
         o_mode_supported <= 1'b1;
         o_drivers_en <= 1'b0;
         o_differential <= 1'b0;
         o_loopback_mode <= 1'b0;
         o_two_wire <= 1'b0;
         o_term_en <= 1'b0;
         o_remote_loop_ctrl <= 1'b0;
         o_local_loop_ctrl <= 1'b0;
      end else begin
         o_controller_sync_pin <= sync_nxt;
         o_controller_rtx_clock_pin <= loop_and_clock_select_r[`SSBCR_LK_RXC_BIT] ? pclk_s : rxc_s;
         o_tx_element_timing_out <= tx_element_timing_out_nxt;
         // timing driver either tracks the data driver or stays on whenever drivers are on
         o_tx_timing_en <= dec_drv & (timing_follows_tx_driver ? txen_s : 1'b1);
         // the baud reference is only passed through; sampling at 10 MHz limits its fidelity
         o_baud_ref_clk <= osc_s;
         o_echo_disable <= line_interface_control_r[`SSBCR_LC_ECHO_DIS_BIT];
         o_line_mode_code <= line_interface_control_r[`SSBCR_LC_MODE_MSB:`SSBCR_LC_MODE_LSB];
         o_mode_supported <= dec_supported;
         o_drivers_en <= dec_drv;
         o_differential <= dec_diff;
         o_loopback_mode <= dec_loop;
         o_two_wire <= dec_two;
         o_term_en <= dec_term;
         o_remote_loop_ctrl <= loop_and_clock_select_r[`SSBCR_LK_REMOTE_BIT];
         o_local_loop_ctrl <= loop_and_clock_select_r[`SSBCR_LK_LOCAL_BIT];
      end
   end
endmodule // ssbcr_regs

/* File: include/ssbcr_defs.vh */
`ifndef SSBCR_DEFS_VH
`define SSBCR_DEFS_VH
// ----------------------------------------
// register offsets within the 16-location window
// ----------------------------------------
`define SSBCR_WIN_SIZE 16
`define SSBCR_OFF_STATUS 4'h4
`define SSBCR_OFF_LINE_CTRL 4'h5
`define SSBCR_OFF_LOOP_CLK 4'h6
`define SSBCR_OFF_CID_LO 4'he
`define SSBCR_OFF_CID_HI 4'hf
// ----------------------------------------
// field positions
// ----------------------------------------
`define SSBCR_ST_IRQ_BIT 6
`define SSBCR_ST_DSR_BIT 0
`define SSBCR_LC_TIMING_SW_BIT 7
`define SSBCR_LC_ECHO_DIS_BIT 6
`define SSBCR_LC_SYNC_RTS_BIT 5
`define SSBCR_LC_SYNC_CTS_BIT 4
`define SSBCR_LC_MODE_MSB 3
`define SSBCR_LC_MODE_LSB 0
`define SSBCR_LK_REMOTE_BIT 3
`define SSBCR_LK_LOCAL_BIT 2
`define SSBCR_LK_TSRC_BIT 1
`define SSBCR_LK_RXC_BIT 0
// ----------------------------------------
// line mode codes
// ----------------------------------------
`define SSBCR_MODE_HIZ 4'h0
`define SSBCR_MODE_RS232 4'h2
`define SSBCR_MODE_RS485_TERM 4'h4
`define SSBCR_MODE_RS485 4'h5
`define SSBCR_MODE_SE_LOOP 4'ha
`define SSBCR_MODE_DIFF_LOOP 4'hb
`define SSBCR_MODE_RS530 4'hd
`define SSBCR_MODE_V35 4'he
`define SSBCR_MODE_RS530A 4'hf
// ----------------------------------------
// reset values
// ----------------------------------------
`define SSBCR_RST_LINE_CTRL 8'h00
`define SSBCR_RST_LOOP_CLK 4'h0
`define SSBCR_CID_DEFAULT 16'hffff
// ----------------------------------------
// timing: reference oscillator for the controller baud generator, and the 10 MHz system clock
// ----------------------------------------
`define SSBCR_REF_OSC_HZ 7372800
`define SSBCR_SYS_CLK_HZ 10000000
`endif

/* File: verilog/ssbcr_sync2.v */
`timescale 1ns/1ps
// two-stage synchroniser for one pin level
module ssbcr_sync2 (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_rst_val,
   input wire i_async,
   output reg o_sync
);
   reg meta_r;
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         // synchronous reset, so the idle level can come from the instance
         meta_r <= i_rst_val;
         o_sync <= i_rst_val;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule // ssbcr_sync2

/* File: verilog/ssbcr_mode_dec.v */
`timescale 1ns/1ps
`include "ssbcr_defs.vh"
// decodes the line mode code into transceiver controls
module ssbcr_mode_dec (
   input wire [3:0] i_line_mode_code,
   output reg o_supported,
   output reg o_term_en,
   output reg o_drivers_en,
   output reg o_differential,
   output reg o_loopback,
   output reg o_two_wire
);
   always @* begin
      o_supported = 1'b1;
      o_term_en = 1'b0;
      o_drivers_en = 1'b1;
      o_differential = 1'b0;
      o_loopback = 1'b0;
      o_two_wire = 1'b0;
      case (i_line_mode_code)
         `SSBCR_MODE_HIZ: begin
            o_drivers_en = 1'b0;
         end
         `SSBCR_MODE_RS232: begin
            o_differential = 1'b0;
         end
         `SSBCR_MODE_RS485_TERM: begin
            o_differential = 1'b1;
            o_two_wire = 1'b1;
            o_term_en = 1'b1;
         end
         `SSBCR_MODE_RS485: begin
            o_differential = 1'b1;
            o_two_wire = 1'b1;
         end
         `SSBCR_MODE_SE_LOOP: begin
            o_loopback = 1'b1;
         end
         `SSBCR_MODE_DIFF_LOOP: begin
            o_loopback = 1'b1;
            o_differential = 1'b1;
         end
         `SSBCR_MODE_RS530, `SSBCR_MODE_RS530A, `SSBCR_MODE_V35: begin
            o_differential = 1'b1;
            o_term_en = 1'b1;
         end
         default: begin
            // unsupported codes are treated like high impedance so nothing drives the cable
            o_supported = 1'b0;
            o_drivers_en = 1'b0;
         end
      endcase
   end
endmodule // ssbcr_mode_dec

/* File: testbench/ssbcr_regs_sva.sv */
`timescale 1ns/1ps
// ----
// port checker for the register bank
// ----
module ssbcr_regs_sva #(
   parameter [15:0] CUSTOMER_ID = 16'hffff
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_cs,
   input wire [3:0] i_addr,
   input wire i_rd,
   input wire i_wr,
   input wire [7:0] i_wdata,
   input wire [7:0] o_rdata,
   input wire o_rdata_valid,
   input wire o_controller_sync_pin,
   input wire o_echo_disable,
   input wire [3:0] o_line_mode_code,
   input wire o_drivers_en,
   input wire o_loopback_mode,
   input wire o_two_wire,
   input wire o_term_en
);
   default clocking dck @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   wire rh = i_cs && i_rd;
   wire w5 = i_cs && i_wr && i_addr == 4'h5;
   AST_RD_ANSWER: assert property (rh |=> o_rdata_valid) else $error("no valid");
   AST_NO_SPUR: assert property (!rh |=> !o_rdata_valid) else $error("stray valid");
   AST_STATUS_ZERO: assert property (rh && i_addr == 4'h4 |=> (o_rdata & 8'hbe) == 8'h00) else $error("st");
   AST_CID_LO: assert property (rh && i_addr == 4'he |=> o_rdata == CUSTOMER_ID[7:0]) else $error("cid lo");
   AST_CID_HI: assert property (rh && i_addr == 4'hf |=> o_rdata == CUSTOMER_ID[15:8]) else $error("cid hi");
   AST_ECHO: assert property (w5 |-> ##2 o_echo_disable == $past(i_wdata[6], 2)) else $error("echo");
   AST_MODE: assert property (w5 |-> ##2 o_line_mode_code == $past(i_wdata[3:0], 2)) else $error("mode");
   AST_SYNC_HIGH: assert property (w5 && i_wdata[5:4] == 2'h0 |-> ##2 o_controller_sync_pin) else $error("sy");
   AST_TERM: assert property (o_term_en == (o_line_mode_code inside {4'h4, 4'hd, 4'he, 4'hf})) else $error("t");
   AST_TWO_WIRE: assert property (o_two_wire == (o_line_mode_code[3:1] == 3'h2)) else $error("2w");
   AST_LOOP: assert property (o_loopback_mode == (o_line_mode_code[3:1] == 3'h5)) else $error("lb");
   AST_HIZ: assert property (o_line_mode_code == 4'h0 |-> !o_drivers_en) else $error("hiz");
   cover property (rh && i_addr == 4'h4);
   cover property (w5 && i_wdata[3:0] == 4'h4);
   cover property (rh && i_addr == 4'hf);
endmodule // ssbcr_regs_sva
bind ssbcr_regs ssbcr_regs_sva #(.CUSTOMER_ID(CUSTOMER_ID)) u_sva (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs(i_cs), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr),
   .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
   .o_controller_sync_pin(o_controller_sync_pin), .o_echo_disable(o_echo_disable),
   .o_line_mode_code(o_line_mode_code), .o_drivers_en(o_drivers_en), .o_loopback_mode(o_loopback_mode),
   .o_two_wire(o_two_wire), .o_term_en(o_term_en)
);

/* File: testbench/ssbcr_partner.sv */
`timescale 1ns/1ps
// ----
// far side: controller and transceiver pins
// ----
module ssbcr_partner (
   input wire i_ref_clk,
   input wire [8:0] i_lvl,
   output reg [8:0] o_pins,
   output reg o_osc
);
   initial o_pins = 9'h003;
   initial o_osc = 1'h0;
   always #67.817 o_osc = ~o_osc;
   // levels move just after the edge, never racing the synchronisers
   always @(posedge i_ref_clk) o_pins <= #1 i_lvl;
endmodule // ssbcr_partner

/* File: testbench/sync_serial_board_control_regs_tb_top.sv */
`timescale 1ns/1ps
// ----
// register bank bench
// ----
module sync_serial_board_control_regs_tb_top;
   logic i_ref_clk = 1'h0, i_rst = 1'h1, i_cs = 1'h0, i_rd = 1'h0, i_wr = 1'h0, sup, bq;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] mdl [0:15];
   logic [8:0] lvl = 9'h003, pins;
   wire i_controller_irq_n, i_dataset_ready_n, i_rts_line, i_cts_line, i_rx_clk_line, i_tx_clk_line;
   wire i_controller_trx_clock_pin, i_peripheral_clk, i_ref_osc_clk, i_tx_driver_en;
   wire [7:0] o_rdata;
   wire [3:0] o_line_mode_code;
   wire o_rdata_valid, o_controller_sync_pin, o_controller_rtx_clock_pin, o_tx_element_timing_out;
   wire o_tx_timing_en, o_baud_ref_clk, o_echo_disable, o_mode_supported, o_drivers_en, o_differential;
   wire o_loopback_mode, o_two_wire, o_term_en, o_remote_loop_ctrl, o_local_loop_ctrl;
   integer errors = 0, total_checks = 0, m5, m6, k, n;
   always #50 i_ref_clk = ~i_ref_clk;
   assign {i_tx_driver_en, i_peripheral_clk, i_controller_trx_clock_pin, i_tx_clk_line, i_rx_clk_line,
      i_cts_line, i_rts_line, i_dataset_ready_n, i_controller_irq_n} = pins;
   ssbcr_partner far (.i_ref_clk(i_ref_clk), .i_lvl(lvl), .o_pins(pins), .o_osc(i_ref_osc_clk));
   ssbcr_regs dut (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs(i_cs), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
      .i_controller_irq_n(i_controller_irq_n), .i_dataset_ready_n(i_dataset_ready_n), .i_rts_line(i_rts_line),
      .i_cts_line(i_cts_line), .i_rx_clk_line(i_rx_clk_line), .i_tx_clk_line(i_tx_clk_line),
      .i_controller_trx_clock_pin(i_controller_trx_clock_pin), .i_peripheral_clk(i_peripheral_clk),
      .i_ref_osc_clk(i_ref_osc_clk), .i_tx_driver_en(i_tx_driver_en),
      .o_controller_sync_pin(o_controller_sync_pin), .o_controller_rtx_clock_pin(o_controller_rtx_clock_pin),
      .o_tx_element_timing_out(o_tx_element_timing_out), .o_tx_timing_en(o_tx_timing_en),
      .o_baud_ref_clk(o_baud_ref_clk), .o_echo_disable(o_echo_disable), .o_line_mode_code(o_line_mode_code),
      .o_mode_supported(o_mode_supported), .o_drivers_en(o_drivers_en), .o_differential(o_differential),
      .o_loopback_mode(o_loopback_mode), .o_two_wire(o_two_wire), .o_term_en(o_term_en),
      .o_remote_loop_ctrl(o_remote_loop_ctrl), .o_local_loop_ctrl(o_local_loop_ctrl)
   );
   task complete_run;
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h00, e}, {7'h00, g});
   endtask
   task automatic idle(input integer c);
      repeat (c) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      idle(1);
      {i_cs, i_wr, i_addr, i_wdata} = {2'h3, a, d};
      // model: offset 5 keeps all bits, offset 6 the low nibble, the rest drop writes
      if (a == 4'h5) mdl[5] = d;
      if (a == 4'h6) mdl[6] = {4'h0, d[3:0]};
      idle(1);
      {i_cs, i_wr} = 2'h0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      idle(1);
      {i_cs, i_rd, i_addr} = {2'h3, a};
      idle(1);
      {i_cs, i_rd} = 2'h0;
      for (n = 0; n < 4 && o_rdata_valid !== 1'h1; n++) idle(1);
      if (n == 4) begin
         errors++;
         complete_run;
      end else begin
         chk8($sformatf("rdata_%h", a), e, o_rdata);
      end
   endtask
   initial begin
      k = $urandom(67);
      idle(6);
      i_rst = 1'h0;
      rdc(4'h4, 8'h41);
      rdc(4'h5, 8'h00);
      rdc(4'h6, 8'h00);
      rdc(4'he, 8'hff);
      rdc(4'hf, 8'hff);
      rdc(4'h0, 8'h00);
      for (k = 0; k < 16; k++) begin
         m5 = ($urandom & 8'hf0) | k;
         wr(4'h5, m5[7:0]);
         rdc(4'h5, m5[7:0]);
         sup = k inside {0, 2, 4, 5, 10, 11, 13, 14, 15};
         chk8("mode", {4'h0, k[3:0]}, {4'h0, o_line_mode_code});
         chk1("supported", sup, o_mode_supported);
         chk1("drivers", sup && k != 0, o_drivers_en);
         chk1("differential", k inside {4, 5, 11, 13, 14, 15}, o_differential);
         chk1("term", k inside {4, 13, 14, 15}, o_term_en);
         chk1("two_wire", k inside {4, 5}, o_two_wire);
         chk1("loopback", k inside {10, 11}, o_loopback_mode);
         chk1("echo_dis", m5[6], o_echo_disable);
      end
      wr(4'h4, 8'h00);
      wr(4'he, 8'h00);
      rdc(4'h5, mdl[5]);
      rdc(4'he, 8'hff);
      for (k = 0; k < 32; k++) begin
         lvl = 9'($urandom);
         m5 = ($urandom & 8'hb0) | 13;
         m6 = $urandom & 15;
         wr(4'h5, m5[7:0]);
         wr(4'h6, m6[7:0]);
         rdc(4'h6, mdl[6]);
         rdc(4'h4, {1'h0, lvl[0], 5'h00, lvl[1]});
         chk1("sync", (!m5[5] | lvl[2]) & (!m5[4] | lvl[3]), o_controller_sync_pin);
         chk1("rtx_clk", m6[0] ? lvl[7] : lvl[4], o_controller_rtx_clock_pin);
         chk1("timing", m6[1] ? lvl[5] : lvl[6], o_tx_element_timing_out);
         chk1("timing_en", m5[7] ? lvl[8] : 1'h1, o_tx_timing_en);
         chk1("remote", m6[3], o_remote_loop_ctrl);
         chk1("local", m6[2], o_local_loop_ctrl);
      end
      m6 = 0;
      bq = o_baud_ref_clk;
      for (k = 0; k < 200; k++) begin
         idle(1);
         if (o_baud_ref_clk && !bq) m6++;
         bq = o_baud_ref_clk;
      end
      chk1("baud_ref", 1'h1, m6 > 20);
      wr(4'h5, 8'hff);
      i_rst = 1'h1;
      idle(6);
      i_rst = 1'h0;
      rdc(4'h5, 8'h00);
      chk1("sync_rst", 1'h1, o_controller_sync_pin);
      complete_run;
   end
endmodule // sync_serial_board_control_regs_tb_top
